//--- verilog/port_ctl_pkg.sv
// Shared constants and types of the port pin control block
package port_ctl_pkg;

    // Register bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [7:0] OFF_BUS_HI_DATA = 8'h00;
    localparam logic [7:0] OFF_BUS_LO_DATA = 8'h01;
    localparam logic [7:0] OFF_BUS_HI_DIR = 8'h02;
    localparam logic [7:0] OFF_BUS_LO_DIR = 8'h03;
    localparam logic [7:0] OFF_CTL_DATA = 8'h08;
    localparam logic [7:0] OFF_CTL_DIR = 8'h09;
    localparam logic [7:0] OFF_CTL_ASSIGN = 8'h0a;
    localparam logic [7:0] OFF_MODE = 8'h0b;
    localparam logic [7:0] OFF_INT_CTL = 8'h1e;
    localparam logic [7:0] OFF_PULSE_DATA = 8'h56;
    localparam logic [7:0] OFF_PULSE_DIR = 8'h57;
    localparam logic [7:0] OFF_ANALOG_DATA = 8'h6f;
    localparam logic [7:0] OFF_TIMER_DATA = 8'hae;
    localparam logic [7:0] OFF_TIMER_DIR = 8'haf;
    localparam logic [7:0] OFF_SERIAL_DATA = 8'hd6;
    localparam logic [7:0] OFF_SERIAL_DIR = 8'hd7;
    localparam logic [7:0] OFF_LINK_DATA = 8'hfe;
    localparam logic [7:0] OFF_LINK_DIR = 8'hff;

    // Reset values
    localparam logic [7:0] DIR_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] ASSIGN_RST = 8'h00;
    localparam logic [7:0] INT_CTL_RST = 8'h00;

    // Field positions: assignment register, interrupt control, control port pins
    localparam int ASSIGN_RW_BIT = 2;
    localparam int ASSIGN_STRB_BIT = 3;
    localparam int ASSIGN_BUS_CLOCK_OUT_BIT = 4;
    localparam int ASSIGN_DBE_BIT = 7;
    localparam int INT_EN_BIT = 6;
    localparam int INT_EDGE_BIT = 7;
    localparam int CTL_NONMASKABLE_REQUEST_PIN_PIN = 0;
    localparam int CTL_IRQ_PIN = 1;
    localparam int CTL_MODA_PIN = 5;
    localparam int CTL_MODB_PIN = 6;
    localparam logic [7:0] CTL_DIR_MASK = 8'hfc;
    localparam logic [7:0] FULL_DIR_MASK = 8'hff;

    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int RESET_DRIVE_NS = 16000;
    localparam int RESET_DRIVE_CYCLES = (RESET_DRIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] SETTLE_DONE = 2'h3;

    // Operating modes, gray along single -> narrow -> wide -> peripheral
    typedef enum logic [1:0]
    {
        MODE_SINGLE = 2'b00,
        MODE_NARROW = 2'b01,
        MODE_WIDE = 2'b11,
        MODE_PERIPH = 2'b10
    } op_mode_t;

endpackage

//--- verilog/pin_if.sv
// Pin bundle between the top and one port slice
`timescale 1ns/1ns
interface pin_if #(parameter int W = 8);
    logic [W-1:0] pad_in;
    logic [W-1:0] pad_out;
    logic [W-1:0] pad_oe_n;
    modport port (input pad_in, output pad_out, output pad_oe_n);
    modport pad (output pad_in, input pad_out, input pad_oe_n);
endinterface

//--- verilog/sync2.sv
// Two flip-flop synchroniser for pin levels
`timescale 1ns/1ns
module sync2 #(parameter int W = 1)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Levels
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] stage1_r;

    // First stage feeds only the second
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            stage1_r <= '0;
            sync_out <= '0;
        end
        else
        begin
            stage1_r <= async_in;
            sync_out <= stage1_r;
        end
    end
endmodule

//--- verilog/gpio_port.sv
// One port slice: output latch, direction, alternate override, read-back
`timescale 1ns/1ns
module gpio_port #(
    parameter int W = 8,
    parameter logic [W-1:0] DIR_MASK = '1
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Register side
    input wire logic [W-1:0] wr_data,
    input wire logic data_we,
    input wire logic dir_we,
    output logic [W-1:0] rd_data,
    output logic [W-1:0] dir_q,
    output logic [W-1:0] pin_level,
    // Alternate function side
    input wire logic [W-1:0] alt_en,
    input wire logic [W-1:0] alt_out,
    input wire logic [W-1:0] alt_oe,
    // Pins
    pin_if.port pins
);
    logic [W-1:0] latch_r;
    logic [W-1:0] dir_r;
    wire [W-1:0] drive_en;

    // Width check
    if (W < 1 || W > port_ctl_pkg::DATA_W)
    begin : g_bad_width
        $error("gpio_port width out of range");
    end

    // Latch and direction, all inputs out of reset
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            latch_r <= W'(port_ctl_pkg::DATA_RST);
            dir_r <= W'(port_ctl_pkg::DIR_RST);
        end
        else
        begin
            if (data_we)
                latch_r <= wr_data;
            if (dir_we)
                dir_r <= wr_data & DIR_MASK;
        end
    end

    // Pin level synchroniser
    sync2 #(.W(W)) u_sync (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .async_in(pins.pad_in),
        .sync_out(pin_level)
    );

    // Alternate function overrides direction and latch
    assign drive_en = (alt_en & alt_oe) | (~alt_en & dir_r);
    assign pins.pad_oe_n = ~drive_en;
    assign pins.pad_out = (alt_en & alt_out) | (~alt_en & latch_r);
    assign dir_q = dir_r;
    // Outputs read the latch, inputs read the pin
    assign rd_data = (dir_r & latch_r) | (~dir_r & pin_level);
endmodule

//--- verilog/mcu_port_pin_control.sv
// Port pin control: register map, mode capture, alternate pin routing
`timescale 1ns/1ns
module mcu_port_pin_control #(
    parameter int RESET_DRIVE = port_ctl_pkg::RESET_DRIVE_CYCLES
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Bus port high pins
    input wire logic [7:0] bus_hi_in,
    output logic [7:0] bus_hi_out,
    output logic [7:0] bus_hi_oe_n,
    // Bus port low pins
    input wire logic [7:0] bus_lo_in,
    output logic [7:0] bus_lo_out,
    output logic [7:0] bus_lo_oe_n,
    // Control port pins
    input wire logic [7:0] ctl_in,
    output logic [7:0] ctl_out,
    output logic [7:0] ctl_oe_n,
    // Pulse port pins
    input wire logic [7:0] pulse_in,
    output logic [7:0] pulse_out,
    output logic [7:0] pulse_oe_n,
    // Timer port pins
    input wire logic [7:0] timer_in,
    output logic [7:0] timer_out,
    output logic [7:0] timer_oe_n,
    // Serial port pins
    input wire logic [7:0] serial_in,
    output logic [7:0] serial_out,
    output logic [7:0] serial_oe_n,
    // Link port pins
    input wire logic [7:0] link_in,
    output logic [7:0] link_out,
    output logic [7:0] link_oe_n,
    // Analog port pins, input only
    input wire logic [7:0] analog_port_pins,
    // Reset and debug pins
    input wire logic reset_pin_in,
    output logic reset_pin_out,
    output logic reset_pin_oe_n,
    input wire logic background_debug_pin,
    output logic bus_clock_out,
    // Internal bus master side
    input wire logic [15:0] ext_addr,
    input wire logic [15:0] ext_wdata,
    input wire logic ext_write,
    input wire logic byte_size_access_n,
    output logic [15:0] ext_rdata,
    // Fault sources and interrupt side
    input wire logic watchdog_timeout,
    input wire logic clock_monitor_fail,
    input wire logic irq_ack,
    output logic irq_request,
    output logic nonmaskable_request_pin_request,
    output logic reset_pin_low,
    output logic special_mode,
    output logic [1:0] op_mode,
    // Peripheral functions
    input wire logic [3:0] pwm_enable,
    input wire logic [3:0] pwm_out,
    input wire logic [7:0] timer_chan_en,
    input wire logic [7:0] timer_chan_out,
    input wire logic [7:0] timer_chan_oe,
    input wire logic sci_enable,
    input wire logic spi_enable,
    input wire logic [7:0] serial_alt_out,
    input wire logic [7:0] serial_alt_oe,
    input wire logic link_enable,
    input wire logic [7:0] link_alt_out,
    input wire logic [7:0] link_alt_oe,
    output logic [7:0] timer_level,
    output logic [7:0] serial_level,
    output logic [7:0] link_level
);
    localparam int PN = 7;
    localparam int CNT_W = $clog2(RESET_DRIVE + 1);

    // Range check on the reset stretch
    if (RESET_DRIVE < 1)
    begin : g_bad_drive
        $error("RESET_DRIVE must be at least one cycle");
    end

    // Port slice pins and register links, index: hi lo ctl pulse timer serial link
    pin_if #(.W(8)) pif [PN] ();
    logic [7:0] pin_in [PN];
    logic [7:0] alt_en [PN];
    logic [7:0] alt_out [PN];
    logic [7:0] alt_oe [PN];
    logic [7:0] port_rd [PN];
    logic [7:0] port_dir [PN];
    logic [7:0] port_lvl [PN];
    logic data_we [PN];
    logic dir_we [PN];
    logic data_hit [PN];
    logic dir_hit [PN];
    logic port_map [PN];
    logic [7:0] data_off [PN];
    logic [7:0] dir_off [PN];

    // Control state
    logic [7:0] assign_r;
    logic [7:0] int_ctl_r;
    logic [7:0] reg_rdata_nxt;
    logic bus_clock_out_r;
    logic [1:0] settle_r;
    logic init_done_r;
    logic special_r;
    port_ctl_pkg::op_mode_t mode_r;
    port_ctl_pkg::op_mode_t mode_nxt;
    logic irq_prev_r;
    logic irq_pend_r;
    logic [CNT_W-1:0] rst_cnt_r;
    logic background_debug_pin_lvl;

    // Pin in/out through the interface bundles
    assign pin_in[0] = bus_hi_in;
    assign pin_in[1] = bus_lo_in;
    assign pin_in[2] = ctl_in;
    assign pin_in[3] = pulse_in;
    assign pin_in[4] = timer_in;
    assign pin_in[5] = serial_in;
    assign pin_in[6] = link_in;
    assign bus_hi_out = pif[0].pad_out;
    assign bus_hi_oe_n = pif[0].pad_oe_n;
    assign bus_lo_out = pif[1].pad_out;
    assign bus_lo_oe_n = pif[1].pad_oe_n;
    assign ctl_out = pif[2].pad_out;
    assign ctl_oe_n = pif[2].pad_oe_n;
    assign pulse_out = pif[3].pad_out;
    assign pulse_oe_n = pif[3].pad_oe_n;
    assign timer_out = pif[4].pad_out;
    assign timer_oe_n = pif[4].pad_oe_n;
    assign serial_out = pif[5].pad_out;
    assign serial_oe_n = pif[5].pad_oe_n;
    assign link_out = pif[6].pad_out;
    assign link_oe_n = pif[6].pad_oe_n;

    // Register offsets per port
    assign data_off[0] = port_ctl_pkg::OFF_BUS_HI_DATA;
    assign data_off[1] = port_ctl_pkg::OFF_BUS_LO_DATA;
    assign data_off[2] = port_ctl_pkg::OFF_CTL_DATA;
    assign data_off[3] = port_ctl_pkg::OFF_PULSE_DATA;
    assign data_off[4] = port_ctl_pkg::OFF_TIMER_DATA;
    assign data_off[5] = port_ctl_pkg::OFF_SERIAL_DATA;
    assign data_off[6] = port_ctl_pkg::OFF_LINK_DATA;
    assign dir_off[0] = port_ctl_pkg::OFF_BUS_HI_DIR;
    assign dir_off[1] = port_ctl_pkg::OFF_BUS_LO_DIR;
    assign dir_off[2] = port_ctl_pkg::OFF_CTL_DIR;
    assign dir_off[3] = port_ctl_pkg::OFF_PULSE_DIR;
    assign dir_off[4] = port_ctl_pkg::OFF_TIMER_DIR;
    assign dir_off[5] = port_ctl_pkg::OFF_SERIAL_DIR;
    assign dir_off[6] = port_ctl_pkg::OFF_LINK_DIR;

    // Map presence: bus ports only in single chip, control port not in peripheral
    wire bus_in_map = (mode_r == port_ctl_pkg::MODE_SINGLE);
    wire ctl_in_map = (mode_r != port_ctl_pkg::MODE_PERIPH);
    wire expanded = (mode_r == port_ctl_pkg::MODE_NARROW) || (mode_r == port_ctl_pkg::MODE_WIDE);
    assign port_map[0] = bus_in_map;
    assign port_map[1] = bus_in_map;
    assign port_map[2] = ctl_in_map;
    assign port_map[3] = 1'b1;
    assign port_map[4] = 1'b1;
    assign port_map[5] = 1'b1;
    assign port_map[6] = 1'b1;

    // One slice per port
    for (genvar i = 0; i < PN; i++)
    begin : g_port
        assign pif[i].pad_in = pin_in[i];
        assign data_hit[i] = port_map[i] && (reg_addr == data_off[i]);
        assign dir_hit[i] = port_map[i] && (reg_addr == dir_off[i]);
        assign data_we[i] = reg_wr && data_hit[i];
        assign dir_we[i] = reg_wr && dir_hit[i];
        gpio_port #(
            .W(8),
            .DIR_MASK(i == 2 ? port_ctl_pkg::CTL_DIR_MASK : port_ctl_pkg::FULL_DIR_MASK)
        ) u_port (
            .sys_clk(sys_clk),
            .resetn(resetn),
            .wr_data(reg_wdata),
            .data_we(data_we[i]),
            .dir_we(dir_we[i]),
            .rd_data(port_rd[i]),
            .dir_q(port_dir[i]),
            .pin_level(port_lvl[i]),
            .alt_en(alt_en[i]),
            .alt_out(alt_out[i]),
            .alt_oe(alt_oe[i]),
            .pins(pif[i])
        );
    end

    // Analog port and debug pin synchronisers
    logic [7:0] analog_lvl;
    sync2 #(.W(9)) u_misc_sync (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .async_in({background_debug_pin, analog_port_pins}),
        .sync_out({background_debug_pin_lvl, analog_lvl})
    );

    // Reset pin level synchroniser
    sync2 #(.W(1)) u_rst_sync (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .async_in(~reset_pin_in),
        .sync_out(reset_pin_low)
    );

    // Expanded bus: address while clock low, data while high; in narrow mode the low byte carries address in both phases
    wire wide = (mode_r == port_ctl_pkg::MODE_WIDE);
    wire data_phase = bus_clock_out_r;
    wire [7:0] hi_byte = data_phase ? ext_wdata[15:8] : ext_addr[15:8];
    wire [7:0] lo_byte = (data_phase && wide) ? ext_wdata[7:0] : ext_addr[7:0];
    wire hi_drive = !data_phase || ext_write;
    wire lo_drive = !(data_phase && wide) || ext_write;
    assign alt_en[0] = {8{expanded}};
    assign alt_out[0] = hi_byte;
    assign alt_oe[0] = {8{hi_drive}};
    assign alt_en[1] = {8{expanded}};
    assign alt_out[1] = lo_byte;
    assign alt_oe[1] = {8{lo_drive}};
    assign ext_rdata = {port_lvl[0], port_lvl[1]};

    // Control port: assignment bits override direction
    wire low_byte_strobe = ~(ext_addr[0] ^ byte_size_access_n);
    wire dbe_n = ~bus_clock_out_r;
    assign alt_en[2] = {assign_r[port_ctl_pkg::ASSIGN_DBE_BIT] & expanded, 2'b00,
        assign_r[port_ctl_pkg::ASSIGN_BUS_CLOCK_OUT_BIT], assign_r[port_ctl_pkg::ASSIGN_STRB_BIT],
        assign_r[port_ctl_pkg::ASSIGN_RW_BIT], 2'b00};
    assign alt_out[2] = {dbe_n, 2'b00, bus_clock_out_r, low_byte_strobe, ~ext_write, 2'b00};
    assign alt_oe[2] = 8'hfc;

    // Pulse port: lower four pins follow enabled channels
    assign alt_en[3] = {4'h0, pwm_enable};
    assign alt_out[3] = {4'h0, pwm_out};
    assign alt_oe[3] = 8'h0f;

    // Timer port: channels take their pins when enabled
    assign alt_en[4] = timer_chan_en;
    assign alt_out[4] = timer_chan_out;
    assign alt_oe[4] = timer_chan_oe;
    assign timer_level = port_lvl[4];

    // Serial port: async on bits 1:0, sync on bits 7:4
    assign alt_en[5] = {{4{spi_enable}}, 2'b00, {2{sci_enable}}};
    assign alt_out[5] = serial_alt_out;
    assign alt_oe[5] = serial_alt_oe;
    assign serial_level = port_lvl[5];

    // Link port: link function wins over I/O
    assign alt_en[6] = {8{link_enable}};
    assign alt_out[6] = link_alt_out;
    assign alt_oe[6] = link_alt_oe;
    assign link_level = port_lvl[6];

    // Bus clock divider from the system clock
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            bus_clock_out_r <= 1'b0;
        else
            bus_clock_out_r <= ~bus_clock_out_r;
    end
    assign bus_clock_out = bus_clock_out_r;

    // Mode decode from strap levels
    always_comb
    begin
        mode_nxt = port_ctl_pkg::MODE_SINGLE;
        if (port_lvl[2][port_ctl_pkg::CTL_MODB_PIN] && port_lvl[2][port_ctl_pkg::CTL_MODA_PIN])
            mode_nxt = port_ctl_pkg::MODE_WIDE;
        else if (port_lvl[2][port_ctl_pkg::CTL_MODA_PIN])
            mode_nxt = port_ctl_pkg::MODE_NARROW;
        else if (port_lvl[2][port_ctl_pkg::CTL_MODB_PIN] && !background_debug_pin_lvl)
            mode_nxt = port_ctl_pkg::MODE_PERIPH;
    end

    // Straps caught once the synchronisers have settled after release
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            settle_r <= 2'h0;
            init_done_r <= 1'b0;
            special_r <= 1'b0;
            mode_r <= port_ctl_pkg::MODE_SINGLE;
        end
        else if (!init_done_r)
        begin
            settle_r <= settle_r + 2'h1;
            if (settle_r == port_ctl_pkg::SETTLE_DONE)
            begin
                init_done_r <= 1'b1;
                special_r <= ~background_debug_pin_lvl;
                mode_r <= mode_nxt;
            end
        end
    end
    assign special_mode = special_r;
    assign op_mode = mode_r;

    // Assignment and interrupt control registers
    wire assign_we = reg_wr && ctl_in_map && (reg_addr == port_ctl_pkg::OFF_CTL_ASSIGN);
    wire int_ctl_we = reg_wr && (reg_addr == port_ctl_pkg::OFF_INT_CTL);
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            assign_r <= port_ctl_pkg::ASSIGN_RST;
            int_ctl_r <= port_ctl_pkg::INT_CTL_RST;
        end
        else
        begin
            if (assign_we)
                assign_r <= reg_wdata;
            if (int_ctl_we)
                int_ctl_r <= reg_wdata;
        end
    end

    // Maskable request: falling edge latch or low level
    wire irq_lvl = port_lvl[2][port_ctl_pkg::CTL_IRQ_PIN];
    wire irq_fall = irq_prev_r && !irq_lvl;
    wire edge_mode = int_ctl_r[port_ctl_pkg::INT_EDGE_BIT];
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            irq_prev_r <= 1'b0;
            irq_pend_r <= 1'b0;
        end
        else
        begin
            irq_prev_r <= irq_lvl;
            if (irq_fall && edge_mode)
                irq_pend_r <= 1'b1;
            else if (irq_ack || !edge_mode)
                irq_pend_r <= 1'b0;
        end
    end
    assign irq_request = int_ctl_r[port_ctl_pkg::INT_EN_BIT]
        && (edge_mode ? irq_pend_r : !irq_lvl);
    assign nonmaskable_request_pin_request = init_done_r && !port_lvl[2][port_ctl_pkg::CTL_NONMASKABLE_REQUEST_PIN_PIN];

    // Reset pin pulled low for a stretch after a watchdog or clock fault
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            rst_cnt_r <= '0;
        else if (watchdog_timeout || clock_monitor_fail)
            rst_cnt_r <= CNT_W'(RESET_DRIVE);
        else if (rst_cnt_r != '0)
            rst_cnt_r <= rst_cnt_r - 1'b1;
    end
    assign reset_pin_out = 1'b0;
    assign reset_pin_oe_n = (rst_cnt_r == '0);

    // Read decode, unmapped reads return zero
    always_comb
    begin
        reg_rdata_nxt = 8'h00;
        if (data_hit[0])
            reg_rdata_nxt = port_rd[0];
        else if (data_hit[1])
            reg_rdata_nxt = port_rd[1];
        else if (data_hit[2])
            reg_rdata_nxt = port_rd[2];
        else if (data_hit[3])
            reg_rdata_nxt = port_rd[3];
        else if (data_hit[4])
            reg_rdata_nxt = port_rd[4];
        else if (data_hit[5])
            reg_rdata_nxt = port_rd[5];
        else if (data_hit[6])
            reg_rdata_nxt = port_rd[6];
        else if (dir_hit[0])
            reg_rdata_nxt = port_dir[0];
        else if (dir_hit[1])
            reg_rdata_nxt = port_dir[1];
        else if (dir_hit[2])
            reg_rdata_nxt = port_dir[2];
        else if (dir_hit[3])
            reg_rdata_nxt = port_dir[3];
        else if (dir_hit[4])
            reg_rdata_nxt = port_dir[4];
        else if (dir_hit[5])
            reg_rdata_nxt = port_dir[5];
        else if (dir_hit[6])
            reg_rdata_nxt = port_dir[6];
        else if (reg_addr == port_ctl_pkg::OFF_ANALOG_DATA)
            reg_rdata_nxt = analog_lvl;
        else if (ctl_in_map && reg_addr == port_ctl_pkg::OFF_CTL_ASSIGN)
            reg_rdata_nxt = assign_r;
        else if (reg_addr == port_ctl_pkg::OFF_INT_CTL)
            reg_rdata_nxt = int_ctl_r;
        else if (reg_addr == port_ctl_pkg::OFF_MODE)
            reg_rdata_nxt = {special_r, init_done_r, 4'h0, mode_r};
    end

    // Read data stands one cycle after the strobe
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            reg_rdata <= 8'h00;
        else if (reg_rd)
            reg_rdata <= reg_rdata_nxt;
        else
            reg_rdata <= 8'h00;
    end
endmodule

//--- tb/ext_pads.sv
// Far-side pin model for one 8-bit port
`timescale 1ns/1ns
module ext_pads #(parameter logic [7:0] PULL = 8'h5a)
(
    // Pins
    input wire logic [7:0] out,
    input wire logic [7:0] oe_n,
    output logic [7:0] pin
);
    // Released bits show the pull pattern, never the last driven value
    assign pin = (out & ~oe_n) | (PULL & oe_n);
endmodule

//--- tb/port_chk.sv
// Concurrent checks on the port pin control ports
`timescale 1ns/1ns
module port_chk
(
    // Watched ports
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] bus_lo_oe_n,
    input wire logic [7:0] ctl_oe_n,
    input wire logic watchdog_timeout,
    input wire logic reset_pin_oe_n,
    input wire logic bus_clock_out,
    input wire logic nonmaskable_request_pin_request,
    input wire logic [3:0] pwm_enable,
    input wire logic [3:0] pwm_out,
    input wire logic [7:0] pulse_out,
    input wire logic [7:0] pulse_oe_n,
    input wire logic [1:0] op_mode
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // Pin, strobe and mode relations
    property p_rel; !$past(resetn) |-> &bus_lo_oe_n && &ctl_oe_n[7:2]; endproperty
    a_rel: assert property (p_rel) else $error("pin driven after reset");
    property p_rdz; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
    a_rdz: assert property (p_rdz) else $error("read data outside slot");
    property p_inp; ctl_oe_n[1:0] == 2'h3; endproperty
    a_inp: assert property (p_inp) else $error("input-only bit driven");
    property p_xq; !$past(resetn) |-> !nonmaskable_request_pin_request [*4]; endproperty
    a_xq: assert property (p_xq) else $error("early non-maskable request");
    property p_rdr; watchdog_timeout |=> !reset_pin_oe_n [*4] ##1 reset_pin_oe_n; endproperty
    a_rdr: assert property (p_rdr) else $error("reset drive length wrong");
    property p_mod; $past(resetn, 5) |-> $stable(op_mode); endproperty
    a_mod: assert property (p_mod) else $error("mode changed after capture");
    property p_eck; $past(resetn) |-> bus_clock_out != $past(bus_clock_out); endproperty
    a_eck: assert property (p_eck) else $error("bus clock stalled");
    property p_pwm; (~pulse_oe_n[3:0] & ~(pulse_out[3:0] ^ pwm_out) & pwm_enable) == pwm_enable;
    endproperty
    a_pwm: assert property (p_pwm) else $error("pulse channel not routed");
endmodule

//--- tb/tb.sv
// Testbench for the port pin control block
`timescale 1ns/1ns
module tb;
    logic sys_clk, resetn, reg_wr, reg_rd, reset_pin_in, reset_pin_out, reset_pin_oe_n;
    logic background_debug_pin, bus_clock_out, ext_write, byte_size_access_n, watchdog_timeout;
    logic clock_monitor_fail, irq_ack, irq_request, nonmaskable_request_pin_request, reset_pin_low, special_mode;
    logic link_enable, sci_enable, spi_enable;
    logic [1:0] op_mode;
    logic [3:0] pwm_enable, pwm_out;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, bus_hi_in, bus_hi_out, bus_hi_oe_n, bus_lo_in;
    logic [7:0] bus_lo_out, bus_lo_oe_n, ctl_in, ctl_out, ctl_oe_n, pulse_in, pulse_out;
    logic [7:0] pulse_oe_n, timer_in, timer_out, timer_oe_n, serial_in, serial_out, serial_oe_n;
    logic [7:0] link_in, link_out, link_oe_n, analog_port_pins, timer_chan_en, timer_chan_out;
    logic [7:0] timer_chan_oe, serial_alt_out, serial_alt_oe, link_alt_out, link_alt_oe;
    logic [7:0] timer_level, serial_level, link_level, ctl_pull;
    logic [15:0] ext_addr, ext_wdata, ext_rdata;
    logic [7:0] dir_o [6] = '{8'h02, 8'h03, 8'h57, 8'haf, 8'hd7, 8'hff};
    logic [7:0] dat_o [6] = '{8'h00, 8'h01, 8'h56, 8'hae, 8'hd6, 8'hfe};
    int n_fail = 0;
    int samples_checked = 0;
    // Far side of each port and the two-way reset pin
    ext_pads p0 (.out(bus_hi_out), .oe_n(bus_hi_oe_n), .pin(bus_hi_in));
    ext_pads p1 (.out(bus_lo_out), .oe_n(bus_lo_oe_n), .pin(bus_lo_in));
    ext_pads p2 (.out(pulse_out), .oe_n(pulse_oe_n), .pin(pulse_in));
    ext_pads p3 (.out(timer_out), .oe_n(timer_oe_n), .pin(timer_in));
    ext_pads p4 (.out(serial_out), .oe_n(serial_oe_n), .pin(serial_in));
    ext_pads p5 (.out(link_out), .oe_n(link_oe_n), .pin(link_in));
    assign ctl_in = (ctl_out & ~ctl_oe_n) | (ctl_pull & ctl_oe_n);
    assign reset_pin_in = reset_pin_oe_n | reset_pin_out;
    mcu_port_pin_control #(.RESET_DRIVE(4)) DUT (.*);
    // Clock
    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e)
        begin
            n_fail++;
            $display("BAD %0t saw %h want %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk) reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk) reg_rd <= 1'b0;
        @(negedge sys_clk) chk(reg_rdata, e);
        @(posedge sys_clk);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Hang guard
    initial
    begin
        #400000;
        n_fail++;
        results();
    end
    // Main sequence
    initial
    begin
        {reg_wr, reg_rd, ext_write, byte_size_access_n, watchdog_timeout, irq_ack} = '0;
        {clock_monitor_fail, link_enable, sci_enable, spi_enable, pwm_enable, pwm_out} = '0;
        {ext_addr, ext_wdata, timer_chan_en, timer_chan_out, timer_chan_oe} = '0;
        {serial_alt_out, serial_alt_oe, link_alt_out, link_alt_oe, reg_addr, reg_wdata} = '0;
        {resetn, background_debug_pin, ctl_pull, analog_port_pins} = {2'b01, 8'h9f, 8'h96};
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (6) @(posedge sys_clk);
        rd(8'h0b, 8'h40);
        rd(8'h6f, 8'h96);
        for (int i = 0; i < 6; i++)
        begin
            rd(dir_o[i], 8'h00);
            wr(dir_o[i], 8'hff);
            wr(dat_o[i], 8'h3c);
            rd(dat_o[i], 8'h3c);
            wr(dir_o[i], 8'h0f);
            repeat (2) @(posedge sys_clk);
            rd(dat_o[i], 8'h5c);
        end
        chk(pulse_oe_n, 8'hf0);
        chk(ext_rdata[15:8] & ext_rdata[7:0], 8'h5c);
        chk(timer_level & serial_level & link_level, 8'h5c);
        wr(8'h09, 8'hff);
        rd(8'h09, 8'hfc);
        chk(ctl_oe_n, 8'h03);
        wr(8'h0a, 8'h08);
        for (int i = 0; i < 4; i++)
        begin
            {ext_addr[0], byte_size_access_n} <= i[1:0];
            @(negedge sys_clk) chk({7'h0, ctl_out[3]}, {7'h0, i[1] ~^ i[0]});
            @(posedge sys_clk);
        end
        wr(8'h1e, 8'h40);
        ctl_pull[1:0] <= 2'b00;
        repeat (4) @(posedge sys_clk);
        chk({6'h0, nonmaskable_request_pin_request, irq_request}, 8'h03);
        ctl_pull[1:0] <= 2'b11;
        repeat (4) @(posedge sys_clk);
        chk({6'h0, nonmaskable_request_pin_request, irq_request}, 8'h00);
        wr(8'h1e, 8'hc0);
        ctl_pull[1] <= 1'b0;
        repeat (4) @(posedge sys_clk);
        ctl_pull[1] <= 1'b1;
        repeat (4) @(posedge sys_clk);
        chk({7'h0, irq_request}, 8'h01);
        irq_ack <= 1'b1;
        @(posedge sys_clk) irq_ack <= 1'b0;
        @(negedge sys_clk) chk({7'h0, irq_request}, 8'h00);
        @(posedge sys_clk) watchdog_timeout <= 1'b1;
        @(posedge sys_clk) watchdog_timeout <= 1'b0;
        @(negedge sys_clk) chk({7'h0, reset_pin_oe_n}, 8'h00);
        repeat (2) @(negedge sys_clk);
        chk({7'h0, reset_pin_low}, 8'h01);
        @(posedge sys_clk) {pwm_enable, pwm_out} <= 8'h51;
        repeat (8) @(posedge sys_clk);
        {pwm_enable, resetn, background_debug_pin, ctl_pull} <= {4'h0, 2'b00, 8'hbe};
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (6) @(posedge sys_clk);
        rd(8'h0b, 8'hc1);
        wr(8'h02, 8'hff);
        rd(8'h02, 8'h00);
        ext_addr <= 16'h1234;
        @(negedge sys_clk);
        if (bus_clock_out !== 1'b0)
            @(negedge sys_clk);
        chk(bus_hi_out, 8'h12);
        chk(bus_lo_out, 8'h34);
        chk({4'h0, nonmaskable_request_pin_request, special_mode, op_mode}, 8'h0d);
        results();
    end
endmodule
bind mcu_port_pin_control port_chk chk (.*);
